// File: core/scr_crc_if.sv
// Bundle between the register core and the CRC setting latch.
// Assumes both ends share mclk and the synchronised reset.
`timescale 1ns/1ps
interface scr_crc_if;
  logic [1:0] len_sel;
  logic [3:0] seed_field;
  logic width_sel;
  logic cmd_start;
  logic [7:0] poly;
  logic [7:0] seed;
  logic [3:0] crc_bits;
  logic width_16;
  modport core (output len_sel, output seed_field, output width_sel, output cmd_start,
    input poly, input seed, input crc_bits, input width_16);
  modport latch (input len_sel, input seed_field, input width_sel, input cmd_start,
    output poly, output seed, output crc_bits, output width_16);
endinterface

// File: core/scr_crc_latch.sv
// Holds the SPI frame settings in force for the current command.
// Assumes cmd_start pulses once as each SPI command begins, on mclk.
`timescale 1ns/1ps
module scr_crc_latch (
  input wire logic mclk,
  input wire logic rst_sync_b,
  scr_crc_if.latch crc
);
  import scr_pkg::*;

  // Settings only move at a command boundary so a frame never mixes two polynomials
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      crc.poly <= CRC8_POLY;
      crc.seed <= CRC8_SEED_DEF;
      crc.crc_bits <= CRC_BITS_8;
      crc.width_16 <= 1'b0;
    end else if (crc.cmd_start) begin
      crc.width_16 <= crc.width_sel;
      unique case (crc.len_sel)
        CRC_LEN_8: begin
          crc.poly <= CRC8_POLY;
          crc.crc_bits <= CRC_BITS_8;
          crc.seed <= (crc.seed_field == 4'h0) ? CRC8_SEED_DEF : {4'h0, crc.seed_field};
        end
        CRC_LEN_4: begin
          crc.poly <= CRC4_POLY;
          crc.crc_bits <= CRC_BITS_4;
          crc.seed <= (crc.seed_field == 4'h0) ? CRC4_SEED_DEF : {4'h0, crc.seed_field};
        end
        default: begin
          crc.poly <= CRC3_POLY;
          crc.crc_bits <= CRC_BITS_3;
          crc.seed <= (crc.seed_field == 4'h0) ? CRC3_SEED_DEF : {5'h00, crc.seed_field[2:0]};
        end
      endcase
    end
  end

  property p_latch_only_at_start;
    @(posedge mclk) disable iff (!rst_sync_b)
      !crc.cmd_start |=> $stable(crc.poly) && $stable(crc.seed);
  endproperty
  a_latch_only_at_start: assert property (p_latch_only_at_start)
    else $error("CRC setting moved inside a command");

  property p_seed3;
    @(posedge mclk) disable iff (!rst_sync_b)
      crc.cmd_start && crc.len_sel[1] && crc.seed_field == 4'h0
        |=> crc.seed == CRC3_SEED_DEF && crc.crc_bits == CRC_BITS_3;
  endproperty
  a_seed3: assert property (p_seed3)
    else $error("3-bit CRC default seed wrong");
endmodule

// File: core/scr_pkg.sv
// Constants and register map of the sensor configuration register group.
// Assumes a serial front end (SPI or I2C) that turns host frames into one-cycle register strobes.
// Contract
// - Width select bit clear gives 12-bit data field, set gives 16-bit.
// - CRC length 00 is 8-bit poly, 01 is 4-bit x^4+1, 1x is x^3+x+1.
// - 8-bit CRC seeds FFh when seed field zero, else 0000 and seed field.
// - 4-bit CRC seeds 1010 or field; 3-bit seeds 111 or low three bits.
// - New CRC length takes effect for both directions from the next SPI command.
// - New CRC seed takes effect for both directions from the next SPI command.
// - Identity register resets to 00h; reading 00h returns the product code.
// - Client address 00h means I2C address 60h, and reads return 60h.
// - Non-zero client address: low seven bits are the address, full byte reads back.
// - Client address register is readable in SPI and I2C mode.
// - Writes changing filter or content registers reset the DSP path; data undefined meanwhile.
// - Filter code 0010 is 800 Hz, 0011 is 1000 Hz; others flag a status error.
// - Power-on reset returns the filter selection to 1000 Hz.
// - Source-0 words carry pressure for selector 01, temperature for 11.
// - Source-1 words follow their own content selector.
// - Source-1 selector uses the source-0 encoding.
// - Content register is readable and writable in SPI and I2C mode.
// - Identity, address, filter, content registers are covered by array error detection.
package scr_pkg;
  localparam logic [7:0] ADDR_FRAME_CFG = 8'h3D;
  localparam logic [7:0] ADDR_IDENTITY = 8'h3E;
  localparam logic [7:0] ADDR_CLIENT = 8'h3F;
  localparam logic [7:0] ADDR_FILTER = 8'h40;
  localparam logic [7:0] ADDR_CONTENT = 8'h42;

  localparam int FRAME_WIDTH_BIT = 6;
  localparam int CRC_LEN_LSB = 4;
  localparam int CRC_SEED_LSB = 0;
  localparam int LOWPASS_LSB = 4;
  localparam int SRC0_SEL_LSB = 5;
  localparam int SRC1_SEL_LSB = 2;

  localparam logic [7:0] RST_FRAME_CFG = 8'h00;
  localparam logic [7:0] RST_IDENTITY = 8'h00;
  localparam logic [7:0] RST_CLIENT = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h30;
  localparam logic [7:0] RST_CONTENT = 8'h00;

  localparam logic [6:0] DEFAULT_CLIENT_ADDR = 7'h60;
  localparam logic [7:0] DEFAULT_CLIENT_READ = 8'h60;

  localparam logic [3:0] LPF_800HZ = 4'h2;
  localparam logic [3:0] LPF_1000HZ = 4'h3;

  localparam logic [1:0] SEL_PRESSURE = 2'h1;
  localparam logic [1:0] SEL_TEMPERATURE = 2'h3;

  localparam logic [1:0] CRC_LEN_8 = 2'h0;
  localparam logic [1:0] CRC_LEN_4 = 2'h1;
  localparam logic [7:0] CRC8_POLY = 8'h2F;
  localparam logic [7:0] CRC4_POLY = 8'h01;
  localparam logic [7:0] CRC3_POLY = 8'h03;
  localparam logic [7:0] CRC8_SEED_DEF = 8'hFF;
  localparam logic [7:0] CRC4_SEED_DEF = 8'h0A;
  localparam logic [7:0] CRC3_SEED_DEF = 8'h07;
  localparam logic [3:0] CRC_BITS_8 = 4'h8;
  localparam logic [3:0] CRC_BITS_4 = 4'h4;
  localparam logic [3:0] CRC_BITS_3 = 4'h3;

  localparam int CLK_MHZ = 10;
  localparam int DSP_INIT_TIME_US = 100;
  localparam int DSP_INIT_CYCLES = DSP_INIT_TIME_US * CLK_MHZ;
endpackage

// File: core/scr_regs.sv
// Top of the sensor configuration register group: registers, read substitution, DSP restart, data routing.
// Assumes the serial front end gives one-cycle register strobes on mclk and pulses cmd_start per SPI command.
`timescale 1ns/1ps
module scr_regs #(
  parameter int INIT_CYCLES = scr_pkg::DSP_INIT_CYCLES,
  parameter logic [7:0] PRODUCT_ID = 8'h5A // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic cmd_start,
  input wire logic [15:0] pressure_in,
  input wire logic [15:0] temperature_in,
  input wire logic sample_valid,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [6:0] client_addr,
  output logic width_16,
  output logic [7:0] crc_poly,
  output logic [7:0] crc_seed,
  output logic [3:0] crc_bits,
  output logic [3:0] lowpass_select,
  output logic lowpass_error,
  output logic dsp_restart,
  output logic dsp_ready,
  output logic array_error,
  output logic [15:0] sensor_output_word0,
  output logic [15:0] sensor_output_word1
);
  import scr_pkg::*;

  logic rst_meta_b;
  logic rst_sync_b;
  logic [7:0] serial_frame_config;
  logic [7:0] identity_readback;
  logic [7:0] client_address;
  logic [7:0] filter_config;
  logic [7:0] data_content_config;
  logic [4:0] par;
  logic [31:0] init_count;
  logic wr_frame;
  logic wr_ident;
  logic wr_client;
  logic wr_filter;
  logic wr_content;
  logic [1:0] source0_content_select;
  logic [1:0] source1_content_select;
  logic [7:0] next_rdata;

  scr_crc_if crc ();

  function automatic logic [15:0] pick_word(input logic [1:0] sel, input logic [15:0] p, input logic [15:0] t);
    unique case (sel)
      SEL_PRESSURE: pick_word = p;
      SEL_TEMPERATURE: pick_word = t;
      default: pick_word = 16'h0000;
    endcase
  endfunction

  function automatic logic par_ok(input logic [7:0] v, input logic p);
    par_ok = ((^v) == p);
  endfunction

  // Reset released through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign wr_frame = reg_wr && reg_addr == ADDR_FRAME_CFG;
  assign wr_ident = reg_wr && reg_addr == ADDR_IDENTITY;
  assign wr_client = reg_wr && reg_addr == ADDR_CLIENT;
  assign wr_filter = reg_wr && reg_addr == ADDR_FILTER;
  assign wr_content = reg_wr && reg_addr == ADDR_CONTENT;
  assign source0_content_select = data_content_config[SRC0_SEL_LSB +: 2];
  assign source1_content_select = data_content_config[SRC1_SEL_LSB +: 2];

  // Writes are accepted in either serial mode
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      serial_frame_config <= RST_FRAME_CFG;
      identity_readback <= RST_IDENTITY;
      client_address <= RST_CLIENT;
      filter_config <= RST_FILTER;
      data_content_config <= RST_CONTENT;
    end else begin
      if (wr_frame) begin
        serial_frame_config <= reg_wdata;
      end
      if (wr_ident) begin
        identity_readback <= reg_wdata;
      end
      if (wr_client) begin
        client_address <= reg_wdata;
      end
      if (wr_filter) begin
        filter_config <= reg_wdata;
      end
      if (wr_content) begin
        data_content_config <= reg_wdata;
      end
    end
  end

  // Check bits written with each register; an upset in the array then shows as a mismatch
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      par <= {^RST_CONTENT, ^RST_FILTER, ^RST_CLIENT, ^RST_IDENTITY, ^RST_FRAME_CFG};
    end else begin
      if (wr_frame) begin
        par[0] <= ^reg_wdata;
      end
      if (wr_ident) begin
        par[1] <= ^reg_wdata;
      end
      if (wr_client) begin
        par[2] <= ^reg_wdata;
      end
      if (wr_filter) begin
        par[3] <= ^reg_wdata;
      end
      if (wr_content) begin
        par[4] <= ^reg_wdata;
      end
    end
  end

  // Sticky until reset: software cannot trust the array once it has been corrupted
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      array_error <= 1'b0;
    end else if (!par_ok(serial_frame_config, par[0]) || !par_ok(identity_readback, par[1])
        || !par_ok(client_address, par[2]) || !par_ok(filter_config, par[3])
        || !par_ok(data_content_config, par[4])) begin
      array_error <= 1'b1;
    end
  end

  // Read data; the client address answers in both modes, so spi_mode plays no part
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      ADDR_FRAME_CFG: next_rdata = serial_frame_config;
      ADDR_IDENTITY: next_rdata = (identity_readback == 8'h00) ? PRODUCT_ID : identity_readback;
      ADDR_CLIENT: next_rdata = (client_address == 8'h00) ? DEFAULT_CLIENT_READ
        : client_address;
      ADDR_FILTER: next_rdata = filter_config;
      ADDR_CONTENT: next_rdata = data_content_config;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      client_addr <= DEFAULT_CLIENT_ADDR;
      lowpass_select <= RST_FILTER[LOWPASS_LSB +: 4];
      lowpass_error <= 1'b0;
    end else begin
      client_addr <= (client_address == 8'h00) ? DEFAULT_CLIENT_ADDR : client_address[6:0];
      lowpass_select <= filter_config[LOWPASS_LSB +: 4];
      lowpass_error <= filter_config[LOWPASS_LSB +: 4] != LPF_800HZ
        && filter_config[LOWPASS_LSB +: 4] != LPF_1000HZ;
    end
  end

  // Only a real change restarts the DSP; rewriting the same value leaves data flowing
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dsp_restart <= 1'b0;
      dsp_ready <= 1'b0;
      init_count <= 32'(INIT_CYCLES);
    end else if ((wr_filter && reg_wdata != filter_config) || (wr_content && reg_wdata != data_content_config)) begin
      dsp_restart <= 1'b1;
      dsp_ready <= 1'b0;
      init_count <= 32'(INIT_CYCLES);
    end else begin
      dsp_restart <= 1'b0;
      if (init_count != 32'h0) begin
        init_count <= init_count - 32'h1;
      end
      dsp_ready <= init_count <= 32'h1;
    end
  end

  // Words read as zero while the path re-initialises, which covers a host that ignores the wait
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sensor_output_word0 <= 16'h0000;
      sensor_output_word1 <= 16'h0000;
    end else if (!dsp_ready) begin
      sensor_output_word0 <= 16'h0000;
      sensor_output_word1 <= 16'h0000;
    end else if (sample_valid) begin
      sensor_output_word0 <= pick_word(source0_content_select, pressure_in, temperature_in);
      sensor_output_word1 <= pick_word(source1_content_select, pressure_in, temperature_in);
    end
  end

  assign crc.len_sel = serial_frame_config[CRC_LEN_LSB +: 2];
  assign crc.seed_field = serial_frame_config[CRC_SEED_LSB +: 4];
  assign crc.width_sel = serial_frame_config[FRAME_WIDTH_BIT];
  assign crc.cmd_start = cmd_start && spi_mode;
  assign crc_poly = crc.poly;
  assign crc_seed = crc.seed;
  assign crc_bits = crc.crc_bits;
  assign width_16 = crc.width_16;

  scr_crc_latch u_crc_latch (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .crc(crc.latch)
  );

  sequence s_cfg_change;
    (wr_filter && reg_wdata != filter_config) || (wr_content && reg_wdata != data_content_config);
  endsequence

  sequence s_restart_seen;
    dsp_restart && !dsp_ready;
  endsequence

  property p_restart_on_change;
    @(posedge mclk) disable iff (!rst_sync_b)
      s_cfg_change |=> s_restart_seen;
  endproperty
  a_restart_on_change: assert property (p_restart_on_change)
    else $error("Config change did not restart DSP");

  property p_zero_while_init;
    @(posedge mclk) disable iff (!rst_sync_b)
      dsp_restart |=> sensor_output_word0 == 16'h0000 && sensor_output_word1 == 16'h0000;
  endproperty
  a_zero_while_init: assert property (p_zero_while_init)
    else $error("Sensor words not cleared during init");

  property p_identity_sub;
    @(posedge mclk) disable iff (!rst_sync_b)
      reg_rd && reg_addr == ADDR_IDENTITY && identity_readback == 8'h00 |=> reg_rdata == PRODUCT_ID;
  endproperty
  a_identity_sub: assert property (p_identity_sub)
    else $error("Identity read did not substitute product code");

  property p_client_default;
    @(posedge mclk) disable iff (!rst_sync_b)
      client_address == 8'h00 ##1 client_address == 8'h00 |-> client_addr == DEFAULT_CLIENT_ADDR;
  endproperty
  a_client_default: assert property (p_client_default)
    else $error("Default client address not 60h");

  property p_client_read;
    @(posedge mclk) disable iff (!rst_sync_b)
      reg_rd && reg_addr == ADDR_CLIENT && client_address != 8'h00 |=> reg_rdata == $past(client_address);
  endproperty
  a_client_read: assert property (p_client_read)
    else $error("Client address read not the stored byte");

  property p_lpf_error;
    @(posedge mclk) disable iff (!rst_sync_b)
      wr_filter && reg_wdata[7:4] != LPF_800HZ && reg_wdata[7:4] != LPF_1000HZ |-> ##2 lowpass_error;
  endproperty
  a_lpf_error: assert property (p_lpf_error)
    else $error("Bad filter code not flagged");

  property p_invalid_content;
    @(posedge mclk) disable iff (!rst_sync_b)
      sample_valid && dsp_ready && !source0_content_select[0] |=> sensor_output_word0 == 16'h0000;
  endproperty
  a_invalid_content: assert property (p_invalid_content)
    else $error("Invalid content code produced data");

  property p_src1_temp;
    @(posedge mclk) disable iff (!rst_sync_b)
      sample_valid && dsp_ready && source1_content_select == SEL_TEMPERATURE
        |=> sensor_output_word1 == $past(temperature_in);
  endproperty
  a_src1_temp: assert property (p_src1_temp)
    else $error("Source-1 temperature routing wrong");

  property p_crc_next_cmd;
    @(posedge mclk) disable iff (!rst_sync_b)
      wr_frame && !crc.cmd_start |=> $stable(crc_poly);
  endproperty
  a_crc_next_cmd: assert property (p_crc_next_cmd)
    else $error("CRC polynomial changed before next command");

  property p_ready_delay;
    @(posedge mclk) disable iff (!rst_sync_b)
      dsp_restart |-> !dsp_ready [*2];
  endproperty
  a_ready_delay: assert property (p_ready_delay)
    else $error("DSP ready too soon after restart");

  sequence s_client_read;
    reg_rd && reg_addr == ADDR_CLIENT;
  endsequence

  // The answer must come whatever spi_mode shows
  property p_client_read_any_mode;
    @(posedge mclk) disable iff (!rst_sync_b)
      s_client_read |=> reg_rvalid;
  endproperty
  a_client_read_any_mode: assert property (p_client_read_any_mode)
    else $error("Client address read not answered");

  property p_content_read;
    @(posedge mclk) disable iff (!rst_sync_b)
      reg_rd && reg_addr == ADDR_CONTENT |=> reg_rvalid && reg_rdata == $past(data_content_config);
  endproperty
  a_content_read: assert property (p_content_read)
    else $error("Content register read back wrong");

  property p_client_nonzero;
    @(posedge mclk) disable iff (!rst_sync_b)
      client_address != 8'h00 |=> client_addr == $past(client_address[6:0]);
  endproperty
  a_client_nonzero: assert property (p_client_nonzero)
    else $error("Stored client address not in force");

  property p_ready_after_count;
    @(posedge mclk) disable iff (!rst_sync_b)
      $rose(dsp_ready) |-> init_count == 32'h0;
  endproperty
  a_ready_after_count: assert property (p_ready_after_count)
    else $error("DSP ready before init count ran out");

  property p_lpf_valid;
    @(posedge mclk) disable iff (!rst_sync_b)
      wr_filter && reg_wdata[LOWPASS_LSB +: 4] == LPF_800HZ |-> ##2 !lowpass_error;
  endproperty
  a_lpf_valid: assert property (p_lpf_valid)
    else $error("Valid filter code flagged as error");
endmodule

// File: verification/scr_host.sv
// Host controller model: register strobes and SPI command starts, changed on the falling edge.
// Assumes the register group answers a read with a one-cycle valid right after the taking edge.
`timescale 1ns/1ps
module scr_host (
  input wire logic mclk,
  input wire logic reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic spi_mode,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic cmd_start
);
  initial begin
    spi_mode = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cmd_start = 1'b0;
  end

  // Released lines show the inverse so a stale value never passes for a held one
  task automatic req(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap);
    // One edge always passes, so back-to-back strobes never get two assignments in one step
    repeat (gap + 1) @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Reads are allowed whichever mode spi_mode shows
  task automatic rd(input logic [7:0] a, input int gap, output logic [7:0] d);
    bit got;
    got = 1'b0;
    d = 8'hXX;
    req(1'b0, a, 8'h00, gap);
    for (int n = 0; n < 3 && !got; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        got = 1'b1;
      end else begin
        @(negedge mclk);
      end
    end
  endtask

  // The mode stays as set so that the following reads run in that mode
  task automatic cmd(input logic spi);
    spi_mode = spi;
    cmd_start = 1'b1;
    @(negedge mclk);
    cmd_start = 1'b0;
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench of the configuration register group against a register model.
// Assumes the host model drives the register strobes; the bench plays the DSP side.
`timescale 1ns/1ps
module testbench;
  import scr_pkg::*;
  localparam int INIT = 8;
  localparam logic [7:0] PID = 8'hA5; // Arbitrary value
  logic mclk, rst_b, spi_mode, reg_wr, reg_rd, cmd_start, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, crc_poly, crc_seed, d, v, live;
  logic [15:0] pressure_in, temperature_in, sensor_output_word0, sensor_output_word1, p, t;
  logic reg_rvalid, width_16, lowpass_error, dsp_restart, dsp_ready, array_error;
  logic [6:0] client_addr;
  logic [3:0] crc_bits, lowpass_select;
  logic [31:0] seed = 32'h000089F0;
  logic [31:0] r;
  logic [7:0] mdl [0:255];
  logic [7:0] regs [6] = '{8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h42, 8'h41};
  int fails = 0;
  int comparisons = 0;

  scr_regs #(.INIT_CYCLES(INIT), .PRODUCT_ID(PID)) i_dut (.mclk(mclk), .rst_b(rst_b), .spi_mode(spi_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_start(cmd_start),
    .pressure_in(pressure_in), .temperature_in(temperature_in), .sample_valid(sample_valid),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .client_addr(client_addr), .width_16(width_16),
    .crc_poly(crc_poly), .crc_seed(crc_seed), .crc_bits(crc_bits), .lowpass_select(lowpass_select),
    .lowpass_error(lowpass_error), .dsp_restart(dsp_restart), .dsp_ready(dsp_ready),
    .array_error(array_error), .sensor_output_word0(sensor_output_word0),
    .sensor_output_word1(sensor_output_word1));
  scr_host i_host (.mclk(mclk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_start(cmd_start));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h3E: return mdl[a] == 8'h00 ? PID : mdl[a];
      8'h3F: return mdl[a] == 8'h00 ? 8'h60 : mdl[a];
      8'h3D, 8'h40, 8'h42: return mdl[a];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [15:0] exp_word(input logic [1:0] s);
    return s == 2'b01 ? p : (s == 2'b11 ? t : 16'h0000);
  endfunction

  task automatic chk_frame(input logic [7:0] c);
    logic [1:0] l;
    l = c[5:4];
    chk(width_16, c[6]);
    chk(crc_poly, l == 2'b00 ? 8'h2F : (l == 2'b01 ? 8'h01 : 8'h03));
    chk(crc_bits, l == 2'b00 ? 4'h8 : (l == 2'b01 ? 4'h4 : 4'h3));
    if (l == 2'b00) chk(crc_seed, c[3:0] == 4'h0 ? 8'hFF : {4'h0, c[3:0]});
    else if (l == 2'b01) chk(crc_seed, c[3:0] == 4'h0 ? 8'h0A : {4'h0, c[3:0]});
    else chk(crc_seed, c[3:0] == 4'h0 ? 8'h07 : {5'h00, c[2:0]});
  endtask

  // The host keeps off the sensor words until the DSP path is back
  task automatic wait_ready();
    for (int n = 0; n < 40 && dsp_ready !== 1'b1; n++) @(negedge mclk);
    chk(dsp_ready, 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    logic chg;
    chg = (a == 8'h40 || a == 8'h42) && val != mdl[a];
    i_host.req(1'b1, a, val, rnd() % 3);
    if (a inside {8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h42}) mdl[a] = val;
    chk(dsp_restart, chg);
    if (chg) begin
      @(negedge mclk);
      chk(dsp_ready, 1'b0);
      chk(sensor_output_word0, 16'h0000);
      wait_ready();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    i_host.rd(a, rnd() % 3, d);
    chk(d, exp_rd(a));
  endtask

  initial begin
    rst_b = 1'b0;
    sample_valid = 1'b0;
    pressure_in = 16'h0000;
    temperature_in = 16'h0000;
    live = 8'h00;
    for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[8'h40] = 8'h30;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    wait_ready();
    chk(client_addr, 7'h60);
    chk(lowpass_select, 4'h3);
    chk(lowpass_error, 1'b0);
    chk_frame(8'h00);
    foreach (regs[i]) rd_chk(regs[i]);
    // Settings written mid-command must wait for the next SPI command start
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      v = {1'b0, r[8], i[1:0], i < 4 ? 4'h0 : r[3:0]};
      wr(8'h3D, v);
      chk_frame(live);
      i_host.cmd(1'b0);
      chk_frame(live);
      rd_chk(8'h3F);
      i_host.cmd(1'b1);
      chk_frame(v);
      live = v;
      rd_chk(8'h42);
    end
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      v = r[9] ? 8'h00 : r[23:16];
      wr(regs[r[7:0] % 6], v);
      wr(regs[r[7:0] % 6], v);
      rd_chk(regs[r[7:0] % 6]);
      chk(client_addr, mdl[8'h3F] == 8'h00 ? 7'h60 : mdl[8'h3F][6:0]);
      chk(lowpass_select, mdl[8'h40][7:4]);
      chk(lowpass_error, !(mdl[8'h40][7:4] inside {4'h2, 4'h3}));
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h42, {1'b0, i[3:2], 1'b0, i[1:0], 2'b00});
      r = rnd();
      p = r[15:0];
      t = r[31:16];
      pressure_in = p;
      temperature_in = t;
      sample_valid = 1'b1;
      @(negedge mclk);
      sample_valid = 1'b0;
      pressure_in = ~p;
      temperature_in = ~t;
      chk(sensor_output_word0, exp_word(i[3:2]));
      chk(sensor_output_word1, exp_word(i[1:0]));
    end
    // A reset in mid-run must bring every register, the filter included, back to its default
    wr(8'h40, 8'h20);
    repeat (2) @(negedge mclk);
    chk(lowpass_select, 4'h2);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[8'h40] = 8'h30;
    wait_ready();
    chk(lowpass_select, 4'h3);
    chk(client_addr, 7'h60);
    chk_frame(8'h00);
    foreach (regs[i]) rd_chk(regs[i]);
    chk(array_error, 1'b0);
    results();
  end

  // About 20000 cycles, several times what the sequence above needs
  initial begin
    #2000000;
    fails++;
    results();
  end
endmodule
